// ===== hw/spbw_serial_port.sv
// Notes on behaviour
// - Wake enable idles receiver; wake sets rx flag
// - Rising edge after wake clears wake enable
// - Receive buffer read clears wake flag
// - Wake detector needs no baud ticks
// - No ordinary reception while wake enabled
// - Break is start, twelve zeros, stop
// - Break request plus enable and a buffer write sends zeros
// - Hardware clears break request after stop
// - Shifter empty tracks break like characters
// - Wake break reception flags on the falling transition
// - Master mode half duplex, one direction
// - Clocked mode remaps pins to clock/data
// - Master drives clock, idle level from polarity
// - Shifter loads only after last bit
// - Buffer move one cycle, then empty flag
// - Empty flag cleared only by buffer write
// - Shifter empty read only, at transmit control bit one
// - Wake event is falling receive edge
// - Wake enable sits at baud control bit one
`include "spbw_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module spbw_serial_port #(
   parameter int ADDR_W = 8,    // Bus address width
   parameter int DIV_W  = 16    // Baud divisor width
) (
   // Clock and reset
   input  wire logic              mclk_i,
   input  wire logic              rst_n_i,
   // AXI4-Lite write channels
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output var  logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output var  logic              s_axi_wready,
   output var  logic [1:0]        s_axi_bresp,
   output var  logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read channels
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output var  logic              s_axi_arready,
   output var  logic [31:0]       s_axi_rdata,
   output var  logic [1:0]        s_axi_rresp,
   output var  logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Line pins
   input  wire logic              receive_line_i,
   output var  logic              data_o,
   output var  logic              data_oe_o,
   output var  logic              strobe_o,
   output var  logic              strobe_oe_o
);
   import spbw_pkg::*;

   // Logic assumes a 16 bit divisor pair and byte offsets up to 0x20
   if (DIV_W != 16 || ADDR_W < 8) begin : g_chk
      $error("spbw_serial_port: DIV_W must be 16, ADDR_W at least 8");
   end

   // Word decode shared by read and write paths
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0]        off);
      hit = (a[7:2] == off[7:2]) && ((a >> 8) == '0);
   endfunction

   // Register state
   spbw_txctl_s      txctl;       // Transmit control
   spbw_baud_s       baud;        // Baud control
   logic             pen;         // port_enable
   logic [7:0]       irqen;       // Enables, stored only, no irq output
   logic [7:0]       div_hi;      // baud_divisor_high
   logic [7:0]       div_lo;      // baud_divisor_low
   logic [7:0]       txbuf;       // transmit_buffer contents
   logic             buf_full;    // Buffer holds a word
   logic             rx_flag;     // rx_ready_flag
   // Bus side state
   logic [ADDR_W-1:0] aw_addr;    // Held write address
   logic [7:0]        w_byte;     // Held write byte
   logic              w_lane;     // Lane 0 strobe held
   logic              aw_full;    // Address captured
   logic              w_full;     // Data captured
   // Line side state
   logic             rx_meta;     // Synchroniser first stage
   logic             rx_s;        // Synchronised line
   logic             rx_d;        // Delayed for edge find
   spbw_wake_e       wk_state;    // Wake detector
   spbw_tx_e         tx_state;    // Transmitter
   logic [13:0]      shf;         // tx_shift_register, LSB out first
   logic [3:0]       left;        // Bits still to go
   logic             half;        // Second half of a clocked bit
   logic             is_brk;      // Current frame is a break
   logic [DIV_W-1:0] bcnt;        // Baud counter
   logic             tick;        // One cycle baud enable

   // Write decode
   wire wr_go  = aw_full && w_full && !s_axi_bvalid;
   wire wr_ok  = wr_go && w_lane;
   wire wr_txb = wr_ok && hit(aw_addr, `SPBW_OFF_TXBUF);
   wire wr_txc = wr_ok && hit(aw_addr, `SPBW_OFF_TXCTL);
   wire wr_bd  = wr_ok && hit(aw_addr, `SPBW_OFF_BAUD);
   wire wr_map = hit(aw_addr, `SPBW_OFF_FLAG)  ||
                 hit(aw_addr, `SPBW_OFF_IRQEN) ||
                 hit(aw_addr, `SPBW_OFF_RXCTL) ||
                 hit(aw_addr, `SPBW_OFF_TXBUF) ||
                 hit(aw_addr, `SPBW_OFF_TXCTL) ||
                 hit(aw_addr, `SPBW_OFF_BAUD)  ||
                 hit(aw_addr, `SPBW_OFF_DIVHI) ||
                 hit(aw_addr, `SPBW_OFF_DIVLO) ||
                 hit(aw_addr, `SPBW_OFF_RXBUF);
   // Read decode
   wire rd_go   = s_axi_arvalid && s_axi_arready;
   wire rd_rxb  = rd_go && hit(s_axi_araddr, `SPBW_OFF_RXBUF);

   // Mode and line events
   wire sync_m  = txctl.sync && txctl.master;
   wire fall    = rx_d && !rx_s;
   wire rise    = !rx_d && rx_s;
   wire sh_empty = (tx_state == TX_IDLE);
   wire rx_idle = (wk_state != WK_RISE);
   // Half duplex: wake reception in progress holds the shifter back
   wire rx_busy = txctl.sync && (wk_state == WK_RISE);
   // Shifter takes a word only once idle
   wire load    = sh_empty && buf_full && txctl.transmit_enable && pen &&
                  (!txctl.sync || txctl.master) && !rx_busy;
   wire bit_end = tick && (txctl.sync ? half : 1'b1);
   wire last    = bit_end && (left == 4'h1);
   wire wake_set = (wk_state == WK_FALL) && fall;
   wire wake_clr = (wk_state == WK_RISE) && rise;
   wire [DIV_W-1:0] div = baud.wide ? {div_hi, div_lo}
                                    : {8'h00, div_lo};

   // Read data selection
   wire [7:0] rd_flag = {2'h0, rx_flag, !buf_full, 4'h0};
   wire [7:0] rd_txc  = {txctl.master, txctl.nine, txctl.transmit_enable,
                         txctl.sync, txctl.brk, txctl.hspd,
                         sh_empty, txctl.ninth};
   wire [7:0] rd_bd   = {1'b0, rx_idle, 1'b0, baud.pol, baud.wide,
                         1'b0, baud.wake, baud.abd};
   // Receive buffer yields dummy zero content after a wake
   wire [7:0] rd_byte =
      hit(s_axi_araddr, `SPBW_OFF_FLAG)  ? rd_flag :
      hit(s_axi_araddr, `SPBW_OFF_IRQEN) ? irqen :
      hit(s_axi_araddr, `SPBW_OFF_RXCTL) ? {pen, 7'h00} :
      hit(s_axi_araddr, `SPBW_OFF_TXBUF) ? txbuf :
      hit(s_axi_araddr, `SPBW_OFF_TXCTL) ? rd_txc :
      hit(s_axi_araddr, `SPBW_OFF_BAUD)  ? rd_bd :
      hit(s_axi_araddr, `SPBW_OFF_DIVHI) ? div_hi :
      hit(s_axi_araddr, `SPBW_OFF_DIVLO) ? div_lo : 8'h00;
   wire rd_map = hit(s_axi_araddr, `SPBW_OFF_FLAG)  ||
                 hit(s_axi_araddr, `SPBW_OFF_IRQEN) ||
                 hit(s_axi_araddr, `SPBW_OFF_RXCTL) ||
                 hit(s_axi_araddr, `SPBW_OFF_TXBUF) ||
                 hit(s_axi_araddr, `SPBW_OFF_TXCTL) ||
                 hit(s_axi_araddr, `SPBW_OFF_BAUD)  ||
                 hit(s_axi_araddr, `SPBW_OFF_DIVHI) ||
                 hit(s_axi_araddr, `SPBW_OFF_DIVLO) ||
                 rd_rxb;

   // Frame image for the shifter, break overrides the buffer
   wire [13:0] frame =
      txctl.brk   ? 14'h2000 :
      txctl.sync  ? {5'h1F, txctl.ninth && txctl.nine, txbuf} :
      txctl.nine  ? {4'hF, txctl.ninth, txbuf, 1'b0} :
                    {5'h1F, txbuf, 1'b0};
   wire [3:0] flen =
      txctl.brk   ? `SPBW_BRK_BITS :
      txctl.sync  ? (txctl.nine ? `SPBW_SYN9_BITS : `SPBW_SYN8_BITS) :
                    (txctl.nine ? `SPBW_ASY9_BITS : `SPBW_ASY8_BITS);

   // Pin levels, registered below so every pin leaves a flop
   wire shifting    = (tx_state == TX_SHIFT);
   wire next_line   = shifting ? shf[0] : 1'b1;
   wire next_clk    = baud.pol ^ (shifting && half);
   wire next_strobe = (txctl.sync && pen) ? next_clk : next_line;
   wire next_data   = next_line;
   wire next_dat_oe = pen && sync_m && txctl.transmit_enable;
   wire next_stb_oe = pen && (!txctl.sync || txctl.master);

   // AXI write channel handshakes, address and data in either order
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `SPBW_RESP_OKAY;
         aw_full       <= 1'b0;
         w_full        <= 1'b0;
      end else begin
         s_axi_awready <= !aw_full && !s_axi_bvalid &&
                          !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !w_full && !s_axi_bvalid &&
                          !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full <= 1'b1;
         end
         // Response once both halves are in
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? `SPBW_RESP_OKAY : `SPBW_RESP_SLV;
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Captured write payload, no reset needed on data
   always_ff @(posedge mclk_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
         aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_byte <= s_axi_wdata[7:0];
         w_lane <= s_axi_wstrb[0];
      end
   end

   // AXI read channel, one read in flight
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `SPBW_RESP_OKAY;
      end else if (rd_go) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h00_0000, rd_byte};
         s_axi_rresp   <= rd_map ? `SPBW_RESP_OKAY : `SPBW_RESP_SLV;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   // Plain control registers
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         pen    <= 1'b0;
         irqen  <= `SPBW_RST_BYTE;
         div_hi <= `SPBW_RST_BYTE;
         div_lo <= `SPBW_RST_BYTE;
      end else if (wr_ok) begin
         if (hit(aw_addr, `SPBW_OFF_RXCTL)) pen    <= w_byte[`SPBW_RX_PEN];
         if (hit(aw_addr, `SPBW_OFF_IRQEN)) irqen  <= w_byte & 8'h30;
         if (hit(aw_addr, `SPBW_OFF_DIVHI)) div_hi <= w_byte;
         if (hit(aw_addr, `SPBW_OFF_DIVLO)) div_lo <= w_byte;
      end
   end

   // Transmit control; hardware drops break after its stop bit
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         txctl <= '0;
      end else if (wr_txc) begin
         txctl <= {w_byte[7:2], w_byte[0]};
      end else if (last && is_brk) begin
         txctl.brk <= 1'b0;
      end
   end

   // Baud control; wake enable cleared by the closing rising edge
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         baud <= '0;
      end else if (wr_bd) begin
         baud <= {w_byte[4], w_byte[3], w_byte[1], w_byte[0]};
      end else if (wake_clr) begin
         baud.wake <= 1'b0;
      end
   end

   // Buffer fill; only a buffer write empties the flag
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         buf_full <= 1'b0;
         txbuf    <= `SPBW_RST_BYTE;
      end else if (wr_txb) begin
         buf_full <= 1'b1;
         txbuf    <= w_byte;
      end else if (load) begin
         buf_full <= 1'b0;
      end
   end

   // Receive flag, a wake set wins over a same cycle read
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rx_flag <= 1'b0;
      end else if (wake_set) begin
         rx_flag <= 1'b1;
      end else if (rd_rxb) begin
         rx_flag <= 1'b0;
      end
   end

   // Two flop synchroniser, then an edge register
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rx_meta <= 1'b1;
         rx_s    <= 1'b1;
         rx_d    <= 1'b1;
      end else begin
         rx_meta <= receive_line_i;
         rx_s    <= rx_meta;
         rx_d    <= rx_s;
      end
   end

   // Wake detector runs off the core clock, never the baud tick,
   // so it sees edges while the rest of the port is quiet
   // Ordinary reception stays parked while wake is set
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i || !baud.wake) begin
         wk_state <= WK_IDLE;
      end else begin
         unique case (wk_state)
            WK_IDLE: wk_state <= WK_FALL;
            WK_FALL: if (fall) wk_state <= WK_RISE;
            WK_RISE: if (rise) wk_state <= WK_IDLE;
         endcase
      end
   end

   // Baud divider; restarts on a load so the first bit is whole
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i || !pen) begin
         bcnt <= '0;
         tick <= 1'b0;
      end else if (load) begin
         // Preload one count: the registered tick costs a cycle
         bcnt <= (div == '0) ? '0 : DIV_W'(1);
         tick <= (div == '0);
      end else if (bcnt >= div) begin
         bcnt <= '0;
         tick <= 1'b1;
      end else begin
         bcnt <= bcnt + 1'b1;
         tick <= 1'b0;
      end
   end

   // Shifter: right shift with mark fill, one bit per bit time
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         tx_state <= TX_IDLE;
         shf      <= 14'h3FFF;
         left     <= 4'h0;
         half     <= 1'b0;
         is_brk   <= 1'b0;
      end else begin
         unique case (tx_state)
            TX_IDLE: if (load) begin
               tx_state <= TX_SHIFT;
               shf      <= frame;
               left     <= flen;
               half     <= 1'b0;
               is_brk   <= txctl.brk;
            end
            TX_SHIFT: begin
               if (tick && txctl.sync) begin
                  half <= !half;
               end
               if (bit_end) begin
                  shf  <= {1'b1, shf[13:1]};
                  left <= left - 4'h1;
                  if (last) begin
                     tx_state <= TX_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // Registered pins; clock pin idles at the polarity level
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         data_o      <= 1'b1;
         data_oe_o   <= 1'b0;
         strobe_o    <= 1'b1;
         strobe_oe_o <= 1'b0;
      end else begin
         data_o      <= next_data;
         data_oe_o   <= next_dat_oe;
         strobe_o    <= next_strobe;
         strobe_oe_o <= next_stb_oe;
      end
   end

   // Checks on the logic above
   rx_wake_set_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      wake_set |=> rx_flag && !rx_idle)
      else $error("wake edge did not raise rx flag");
   wake_autoclr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      wake_clr && !wr_bd |=> !baud.wake ##1 wk_state == WK_IDLE)
      else $error("wake enable not cleared on rising edge");
   rxbuf_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      rd_rxb && !wake_set |=> !rx_flag)
      else $error("receive buffer read left rx flag set");
   break_frame_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      load && txctl.brk |=> shf == 14'h2000 && left == 4'hE)
      else $error("break frame not thirteen zeros then stop");
   break_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      last && is_brk && !wr_txc |=> !txctl.brk && sh_empty)
      else $error("break request not dropped after stop");
   shift_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      shifting && buf_full && !last |=> buf_full)
      else $error("buffer drained while shifter busy");
   load_empty_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      load && !wr_txb |=> !buf_full && shifting)
      else $error("buffer empty flag not set after move");
   empty_done_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      $rose(sh_empty) |-> $past(last))
      else $error("shifter empty rose before last bit");
   half_duplex_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      rx_busy |-> !load)
      else $error("transmit load during reception");
   clk_idle_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      sync_m && pen && !shifting ##1 sync_m && pen
      |-> strobe_o == $past(baud.pol))
      else $error("clock pin not at idle polarity");
   wake_park_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      !baud.wake |=> wk_state == WK_IDLE)
      else $error("wake detector active without enable");
   // Main scenarios
   cov_break_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
      last && is_brk ##[1:4] load);
   cov_wake_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
      wake_set ##[1:1000] wake_clr);
   cov_sync_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
      load && sync_m ##1 shifting [*8]);
endmodule
`default_nettype wire

// ===== pkg/spbw_defines.svh
`ifndef SPBW_DEFINES_SVH
`define SPBW_DEFINES_SVH
// Register byte offsets, one aligned word each
`define SPBW_OFF_FLAG   8'h00
`define SPBW_OFF_IRQEN  8'h04
`define SPBW_OFF_RXCTL  8'h08
`define SPBW_OFF_TXBUF  8'h0C
`define SPBW_OFF_TXCTL  8'h10
`define SPBW_OFF_BAUD   8'h14
`define SPBW_OFF_DIVHI  8'h18
`define SPBW_OFF_DIVLO  8'h1C
`define SPBW_OFF_RXBUF  8'h20
// Field positions
`define SPBW_FLAG_RX    5
`define SPBW_FLAG_TX    4
`define SPBW_RX_PEN     7
`define SPBW_TX_EMPTY   1
`define SPBW_BD_IDLE    6
// Reset values
`define SPBW_RST_BYTE   8'h00
// Frame lengths in bits
`define SPBW_BRK_BITS   4'hE
`define SPBW_ASY8_BITS  4'hA
`define SPBW_ASY9_BITS  4'hB
`define SPBW_SYN8_BITS  4'h8
`define SPBW_SYN9_BITS  4'h9
// Bus responses
`define SPBW_RESP_OKAY  2'h0
`define SPBW_RESP_SLV   2'h2
`endif

// ===== pkg/spbw_pkg.sv
`default_nettype none
package spbw_pkg;
   // Transmit control fields, bit 7 down to bit 0 minus the empty status
   typedef struct packed {
      logic master;   // master_source_select
      logic nine;     // nine_bit_tx_enable
      logic transmit_enable;     // transmit_enable
      logic sync;     // clocked mode select
      logic brk;      // break_send_request
      logic hspd;     // high speed select, stored only
      logic ninth;    // ninth_tx_bit
   } spbw_txctl_s;
   // Baud control fields
   typedef struct packed {
      logic pol;      // shift_idle_polarity
      logic wide;     // wide_divisor_enable
      logic wake;     // wake_on_edge_enable
      logic abd;      // auto_baud_detect, stored only
   } spbw_baud_s;
   typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} spbw_tx_e;
   typedef enum logic [1:0] {WK_IDLE, WK_FALL, WK_RISE} spbw_wake_e;
endpackage
`default_nettype wire

// ===== tb/spbw_line_node.sv
`timescale 1ns/1ps
`default_nettype none
module spbw_line_node (
   // Clock
   input  wire logic mclk_i,
   // Line towards the port
   output var  logic line_o
);
   // Released line idles high through its pull-up
   initial line_o = 1'b1;
   // Level after an edge, held for hold cycles (short or long)
   task automatic level(input logic v, input int hold);
      @(posedge mclk_i);
      line_o <= v;
      repeat (hold) @(posedge mclk_i);
   endtask
endmodule
`default_nettype wire

// ===== tb/spbw_serial_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spbw_serial_port_tb;
   // Bus and line signals
   logic        mclk_i = 0, rst_n_i = 0;
   logic [7:0]  awaddr = 0, araddr = 0, d;
   logic [31:0] wdata = 0, rdata;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
   logic        rready = 0, awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic        line, data_o, data_oe_o, strobe_o, strobe_oe_o;
   // Monitor state
   logic        cap_en = 0, pol = 0, prev_s = 1, n = 0;
   logic [7:0]  sh;
   int          num_errors = 0, checked = 0, cyc = 0, nb = 0, low_run = 0;
   int          runs[$];
   spbw_serial_port dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .receive_line_i(line), .data_o(data_o), .data_oe_o(data_oe_o),
      .strobe_o(strobe_o), .strobe_oe_o(strobe_oe_o));
   spbw_line_node node (.mclk_i(mclk_i), .line_o(line));
   initial forever #5 mclk_i = ~mclk_i;
   // Low run lengths on the transmit pin, shift clock capture, watchdog
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      prev_s <= strobe_o;
      if (!strobe_o) begin
         low_run <= low_run + 1;
      end else if (low_run != 0) begin
         runs.push_back(low_run);
         low_run <= 0;
      end
      // Data sampled at the mid-bit clock transition
      if (cap_en && prev_s === pol && strobe_o === !pol) begin
         sh <= {data_o, sh[7:1]};
         nb <= nb + 1;
      end
      if (cyc == 20000) begin
         num_errors++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
      checked++;
      if (s !== e) begin
         num_errors++;
         $display("wrong value %s exp %h seen %h", nm, e, s);
      end
   endtask
   // Write: aw and w offered together, each dropped when taken
   task automatic wr(logic [7:0] a, logic [7:0] v);
      logic b;
      b = 0;
      @(posedge mclk_i);
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b) begin
         @(posedge mclk_i);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         b = bvalid;
      end
      bready <= 1'b0;
   endtask
   // Read and compare response code with the low byte
   task automatic rdc(string nm, logic [7:0] a, logic [7:0] e,
                      logic [1:0] er = 2'h0);
      logic b;
      logic [31:0] s;
      b = 0;
      @(posedge mclk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!b) begin
         @(posedge mclk_i);
         if (arready) arvalid <= 1'b0;
         b = rvalid;
         s = {rresp, rdata[29:0]};
      end
      rready <= 1'b0;
      chk(nm, s, {er, 22'h0, e});
   endtask
   initial begin
      void'($urandom(60));
      repeat (5) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      // Reset values, read-only flags, unmapped word
      rdc("flags", 8'h00, 8'h10);
      rdc("txctl", 8'h10, 8'h02);
      rdc("baud idle", 8'h14, 8'h40);
      rdc("unmapped", 8'h3C, 8'h00, 2'h2);
      wr(8'h00, 8'h00);
      rdc("flags ro", 8'h00, 8'h10);
      $display("test reset done");
      // Wake on falling edge, cleared by rising edge and buffer read
      wr(8'h14, 8'h02);
      node.level(1'b0, 10);
      rdc("wake flag", 8'h00, 8'h30);
      rdc("wake busy", 8'h14, 8'h02);
      node.level(1'b1, 10);
      rdc("wake end", 8'h14, 8'h40);
      rdc("dummy", 8'h20, 8'h00);
      rdc("rx clr", 8'h00, 8'h10);
      $display("test wake done");
      // Break then sync byte, divisor 3 gives four cycles a bit
      wr(8'h1C, 8'h03);
      wr(8'h08, 8'h80);
      wr(8'h10, 8'h28);
      runs.delete();
      wr(8'h0C, 8'($urandom));
      wr(8'h0C, 8'h55);
      repeat (150) @(posedge mclk_i);
      chk("break low", runs[0], 52);
      chk("sync start", runs[1], 4);
      rdc("brk clr", 8'h10, 8'h22);
      rdc("tx empty", 8'h00, 8'h10);
      $display("test break done");
      // Synchronous master with random polarity and data
      for (int i = 0; i < 3; i++) begin
         cap_en = 0;
         pol = 1'($urandom);
         d = 8'($urandom);
         // Last pass sends nine bits, ninth bit set and sent after data
         n = (i == 2);
         wr(8'h14, {3'h0, pol, 4'h0});
         wr(8'h10, n ? 8'hF1 : 8'hB0);
         nb = 0;
         cap_en = 1;
         wr(8'h0C, d);
         repeat (100) @(posedge mclk_i);
         chk("sync data", sh, n ? {1'b1, d[7:1]} : d);
         chk("bit count", nb, 8 + n);
         chk("idle clk", strobe_o, pol);
         chk("data drive", data_oe_o, 1);
         chk("clk drive", strobe_oe_o, 1);
      end
      $display("test sync done");
      test_done();
   end
endmodule
`default_nettype wire
